/* File: design/fsmon_top.sv */
// Purpose: Fail-safe monitor of the external oscillator with clock failover.
// Assumes: Oscillator inputs are asynchronous pins sampled by MCLK.
// Notes:   Control bits are plain ports driven from MCLK-domain logic.
`timescale 1ns/1ps

// Overview of operation
// - Monitor works only when its enable is set
// - Monitor covers every external oscillator mode
// - Sample clock is low-frequency oscillator divided by 64
// - Detector latch set on external clock falling edge
// - Detector latch cleared on sample clock rising edge
// - Failure when half sample period sees no external clock falling edge
// - Failure moves clock to internal, sets fail flag
// - Interrupt when fail flag and its enable set
// - Stay internal until sleep, or timer timeout after software selects external again
// - Failover frequency comes from the frequency select field
// - Reset, sleep or timer timeout after a clock select change clears condition
// - Select change restarts timer; timeout returns to external
// - Fail flag not clearable while condition active
// - Detection idle until start-up timer expires
// - External clock and RC modes skip the timer
// - Enable also runs code internally during start-up
module fsmon_top
	import fsmon_pkg::*;
#(
	parameter int OST_EDGES = OST_EDGES_DEF
) (
	input  wire logic              MCLK,
	input  wire logic              RST_B,
	input  wire logic              EXT_CLK,
	input  wire logic              LF_OSC_CLK,
	input  wire logic              INT_OSC_CLK,
	input  wire logic              FAIL_SAFE_MONITOR_ENABLE,
	input  wire logic [MODE_W-1:0] OSC_MODE,
	input  wire logic [FREQ_W-1:0] INTERNAL_OSC_FREQ_SELECT,
	input  wire logic [SCS_W-1:0]  SYSTEM_CLOCK_SELECT,
	input  wire logic              SLEEP_EXEC,
	input  wire logic              WAKE_UP,
	input  wire logic              OSC_FAIL_IRQ_ENABLE,
	input  wire logic              OSC_FAIL_FLAG_CLEAR,
	output logic                   SYS_CLK,
	output logic                   SYS_CLK_ON_INTERNAL,
	output logic [FREQ_W-1:0]      INT_OSC_FREQ,
	output logic                   OSC_FAIL_FLAG,
	output logic                   OSC_FAIL_IRQ,
	output logic                   FAIL_SAFE_ACTIVE,
	output logic                   OST_EXPIRED,
	output logic                   MONITOR_ARMED
);

	localparam int OST_W = $clog2(OST_EDGES + 1);
	localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_EDGES - 1);

	// Parameter and package checks at elaboration
	if (OST_EDGES < 1) begin : g_chk_ost
		$error("OST_EDGES must be at least one");
	end
	if (LF_DIVIDE < 4 || LF_DIVIDE % 2 != 0) begin : g_chk_div
		$error("LF_DIVIDE must be even and at least four");
	end
	if ((1 << LF_CNT_W) < LF_HALF) begin : g_chk_lfw
		$error("LF_CNT_W too narrow for LF_HALF");
	end
	if (SCS_W <= SCS_INTERNAL_BIT) begin : g_chk_scs
		$error("SCS_W does not hold the internal select bit");
	end
	if (MODE_W < 3) begin : g_chk_mode
		$error("MODE_W too narrow for the mode codes");
	end
	if (FREQ_W != 4) begin : g_chk_freq
		$error("FREQ_W must be four");
	end

	// Pin synchronisers: two flops, a third for edge detection
	logic [1:0] ext_sync;
	logic [1:0] lf_sync;
	logic [1:0] int_sync;
	logic       ext_prev;
	logic       lf_prev;
	logic       int_prev;

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			ext_sync <= SYNC_RESET;
			lf_sync  <= SYNC_RESET;
			int_sync <= SYNC_RESET;
		end else begin
			ext_sync <= {ext_sync[0], EXT_CLK};
			lf_sync  <= {lf_sync[0], LF_OSC_CLK};
			int_sync <= {int_sync[0], INT_OSC_CLK};
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			ext_prev <= 1'b0;
			lf_prev  <= 1'b0;
			int_prev <= 1'b0;
		end else begin
			ext_prev <= ext_sync[1];
			lf_prev  <= lf_sync[1];
			int_prev <= int_sync[1];
		end
	end

	logic ext_fall;
	logic lf_rise;
	logic int_fall;

	assign ext_fall = ext_prev & ~ext_sync[1];
	assign lf_rise  = ~lf_prev & lf_sync[1];
	assign int_fall = int_prev & ~int_sync[1];

	// Sample clock: low-frequency oscillator divided by 64
	logic [LF_CNT_W-1:0] lf_cnt;
	logic                sample_clk;
	logic                sample_rise;
	logic                sample_fall;
	logic                sample_edge;

	assign sample_edge = lf_rise & (lf_cnt == LF_HALF_LAST);
	assign sample_rise = sample_edge & ~sample_clk;
	assign sample_fall = sample_edge & sample_clk;

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			lf_cnt     <= '0;
			sample_clk <= 1'b0;
		end else if (lf_rise) begin
			if (lf_cnt == LF_HALF_LAST) begin
				lf_cnt     <= '0;
				sample_clk <= ~sample_clk;
			end else begin
				lf_cnt <= lf_cnt + 1'b1;
			end
		end
	end

	// Mode and select decode
	logic skip_ost;
	logic scs_internal;
	logic [SCS_W-1:0] scs_prev;
	logic scs_change;

	// All external modes are monitored alike; mode only steers the timer
	assign skip_ost = (OSC_MODE == external_clock_mode) ||
		(OSC_MODE == resistor_capacitor_mode);
	assign scs_internal = SYSTEM_CLOCK_SELECT[SCS_INTERNAL_BIT];
	assign scs_change = (SYSTEM_CLOCK_SELECT != scs_prev);

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			scs_prev <= '0;
		else
			scs_prev <= SYSTEM_CLOCK_SELECT;
	end

	// Known external oscillator modes; all are monitored alike
	logic mode_known;

	always_comb begin
		case (OSC_MODE)
			low_power_crystal_mode,
			crystal_mode,
			high_speed_crystal_mode,
			external_clock_mode,
			secondary_timer_mode,
			resistor_capacitor_mode: begin
				mode_known = 1'b1;
			end
			default: begin
				mode_known = 1'b0;
			end
		endcase
	end

	// Oscillator start-up timer
	fsmon_ost_e        ost_state;
	fsmon_ost_e        next_ost_state;
	logic [OST_W-1:0]  ost_cnt;
	logic              restart;
	logic              ost_running;
	logic              ost_timeout;

	// Reset release, wake-up and select change all start the timer
	assign restart = WAKE_UP | scs_change;
	assign ost_running = (ost_state == OST_RUN);
	assign ost_timeout = ost_running & ext_fall & (ost_cnt == OST_LAST);

	always_comb begin
		next_ost_state = ost_state;
		case (ost_state)
			OST_IDLE: begin
				next_ost_state = skip_ost ? OST_DONE : OST_RUN;
			end
			OST_RUN: begin
				if (ost_timeout)
					next_ost_state = OST_DONE;
			end
			OST_DONE: begin
				next_ost_state = OST_DONE;
			end
			OST_SLEEP: begin
				next_ost_state = OST_SLEEP;
			end
			default: begin
				next_ost_state = OST_IDLE;
			end
		endcase
		if (SLEEP_EXEC)
			next_ost_state = OST_SLEEP;
		else if (restart)
			next_ost_state = skip_ost ? OST_DONE : OST_RUN;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			ost_state <= OST_IDLE;
		else
			ost_state <= next_ost_state;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			ost_cnt <= '0;
		else if (restart || SLEEP_EXEC || !ost_running)
			ost_cnt <= '0;
		else if (ext_fall)
			ost_cnt <= ost_cnt + 1'b1;
	end

	// Detector latch and failure decision
	logic det_latch;
	logic armed;
	logic fail_event;
	logic fs_active;

	assign armed = FAIL_SAFE_MONITOR_ENABLE & mode_known &
		(ost_state == OST_DONE) & ~scs_internal & ~fs_active;

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			det_latch <= 1'b0;
		else if (ext_fall)
			det_latch <= 1'b1;
		else if (sample_rise)
			det_latch <= 1'b0;
	end

	// Latch cleared at the rising edge still clear at the falling edge
	assign fail_event = armed & sample_fall & ~det_latch & ~ext_fall;

	// Fail-safe condition
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			fs_active <= 1'b0;
		else if (SLEEP_EXEC)
			fs_active <= 1'b0;
		else if (fail_event)
			fs_active <= 1'b1;
		else if (ost_timeout)
			fs_active <= 1'b0;
	end

	// Sticky failure flag, clearable only once the condition is gone
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			OSC_FAIL_FLAG <= 1'b0;
		else if (fail_event)
			OSC_FAIL_FLAG <= 1'b1;
		else if (OSC_FAIL_FLAG_CLEAR && !fs_active)
			OSC_FAIL_FLAG <= 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			OSC_FAIL_IRQ <= 1'b0;
		else
			OSC_FAIL_IRQ <= OSC_FAIL_FLAG & OSC_FAIL_IRQ_ENABLE;
	end

	// Source choice: internal on failure, software select or start-up
	logic want_int;
	logic sel_int;
	logic two_speed;
	logic mux_busy;

	// Two-speed start-up: run internally while the timer counts
	assign two_speed = FAIL_SAFE_MONITOR_ENABLE & ost_running;

	assign want_int = fs_active | scs_internal | two_speed;
	assign mux_busy = (want_int != sel_int);

	// Glitch-free mux: switch only at the target's falling edge while
	// the output is low; on failure the old clock may be stuck, so the
	// switch is forced, which only lengthens the current phase
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			sel_int <= 1'b0;
		else if (want_int && !sel_int && int_fall &&
			(!SYS_CLK || fs_active))
			sel_int <= 1'b1;
		else if (!want_int && sel_int && ext_fall && !SYS_CLK)
			sel_int <= 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			SYS_CLK <= 1'b0;
		else if (mux_busy)
			SYS_CLK <= SYS_CLK & ~(int_fall | ext_fall);
		else
			SYS_CLK <= sel_int ? int_sync[1] : ext_sync[1];
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			INT_OSC_FREQ <= FREQ_RESET;
		else
			INT_OSC_FREQ <= INTERNAL_OSC_FREQ_SELECT;
	end

	// Status for software polling after start-up
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			SYS_CLK_ON_INTERNAL <= 1'b0;
			FAIL_SAFE_ACTIVE    <= 1'b0;
			OST_EXPIRED         <= 1'b0;
			MONITOR_ARMED       <= 1'b0;
		end else begin
			SYS_CLK_ON_INTERNAL <= sel_int;
			FAIL_SAFE_ACTIVE    <= fs_active;
			OST_EXPIRED         <= (ost_state == OST_DONE);
			MONITOR_ARMED       <= armed;
		end
	end

endmodule : fsmon_top

/* File: design/fsmon_pkg.sv */
// Purpose: Constants and types shared by the fail-safe clock monitor.
// Assumes: One 250 MHz clock; all oscillators arrive as sampled pins.
// Notes:   Counts are in oscillator edges unless named in MCLK cycles.
package fsmon_pkg;

	// Clock period of MCLK in picoseconds
	localparam int MCLK_PERIOD_PS     = 4000;

	// Sample clock divider on the low-frequency oscillator
	localparam int LF_DIVIDE          = 64;
	localparam int LF_HALF            = LF_DIVIDE / 2;
	localparam int LF_CNT_W           = $clog2(LF_HALF);
	localparam logic [LF_CNT_W-1:0] LF_HALF_LAST = LF_CNT_W'(LF_HALF - 1);

	// Default start-up timer length in external clock falling edges
	localparam int OST_EDGES_DEF      = 1024;

	// Widths
	localparam int FREQ_W             = 4;
	localparam int SCS_W              = 2;
	localparam int MODE_W             = 3;

	// Reset values
	localparam logic [FREQ_W-1:0] FREQ_RESET   = 4'h0;
	localparam logic [1:0]        SYNC_RESET   = 2'h0;

	// System clock select encodings; bit 1 set picks the internal oscillator
	localparam int SCS_INTERNAL_BIT   = 1;

	// External oscillator modes
	typedef enum logic [MODE_W-1:0] {
		low_power_crystal_mode  = 3'b000,
		crystal_mode            = 3'b001,
		high_speed_crystal_mode = 3'b010,
		external_clock_mode     = 3'b011,
		secondary_timer_mode    = 3'b100,
		resistor_capacitor_mode = 3'b101
	} fsmon_mode_e;

	// Start-up timer states
	typedef enum logic [1:0] {
		OST_IDLE  = 2'b00,
		OST_RUN   = 2'b01,
		OST_DONE  = 2'b10,
		OST_SLEEP = 2'b11
	} fsmon_ost_e;

endpackage : fsmon_pkg

/* File: dv/fsmon_ext_osc.sv */
// Purpose: External oscillator model for the fail-safe clock monitor.
// Assumes: Half period is half plus one MCLK cycles, half at least 1.
// Notes:   A dead oscillator parks high, so no falling edge is seen.
`timescale 1ns/1ps
module fsmon_ext_osc (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [3:0] half,
	output logic            osc
);
	logic [3:0] cnt = 4'h0;
	initial osc = 1'b1;
	always @(posedge clk) begin
		if (!run) begin
			osc <= 1'b1;
			cnt <= 4'h0;
		end else if (cnt >= half) begin
			osc <= ~osc;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : fsmon_ext_osc

/* File: dv/fsmon_asserts.sv */
// Purpose: Port assertions for the fail-safe clock monitor.
// Assumes: One MCLK domain, RST_B synchronous and active low.
// Notes:   Bound to every fsmon_top instance.
`timescale 1ns/1ps
module fsmon_asserts
	import fsmon_pkg::*;
(
	input wire logic              MCLK,
	input wire logic              RST_B,
	input wire logic              FAIL_SAFE_MONITOR_ENABLE,
	input wire logic [MODE_W-1:0] OSC_MODE,
	input wire logic [FREQ_W-1:0] INTERNAL_OSC_FREQ_SELECT,
	input wire logic              SLEEP_EXEC,
	input wire logic              WAKE_UP,
	input wire logic              OSC_FAIL_IRQ_ENABLE,
	input wire logic              OSC_FAIL_FLAG_CLEAR,
	input wire logic              SYS_CLK,
	input wire logic              SYS_CLK_ON_INTERNAL,
	input wire logic [FREQ_W-1:0] INT_OSC_FREQ,
	input wire logic              OSC_FAIL_FLAG,
	input wire logic              OSC_FAIL_IRQ,
	input wire logic              FAIL_SAFE_ACTIVE,
	input wire logic              OST_EXPIRED,
	input wire logic              MONITOR_ARMED
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	a_irq_from_flag:
	assert property (OSC_FAIL_IRQ ==
		$past(OSC_FAIL_FLAG & OSC_FAIL_IRQ_ENABLE)) else $error("irq wrong");
	a_flag_stays_set:
	assert property (OSC_FAIL_FLAG && !OSC_FAIL_FLAG_CLEAR |=> OSC_FAIL_FLAG)
		else $error("flag dropped");
	a_clear_refused:
	assert property (OSC_FAIL_FLAG && FAIL_SAFE_ACTIVE |=>
		OSC_FAIL_FLAG || !FAIL_SAFE_ACTIVE)
		else $error("flag cleared while active");
	a_fail_needs_enable:
	assert property ($rose(OSC_FAIL_FLAG) |-> $past(FAIL_SAFE_MONITOR_ENABLE))
		else $error("fail while disabled");
	a_freq_copy:
	assert property ($past(RST_B) |->
		INT_OSC_FREQ == $past(INTERNAL_OSC_FREQ_SELECT)) else $error("freq");
	a_fail_to_internal:
	assert property ($rose(FAIL_SAFE_ACTIVE) |-> ##[0:64] SYS_CLK_ON_INTERNAL)
		else $error("no failover");
	a_switch_clock_low:
	assert property ($changed(SYS_CLK_ON_INTERNAL) |-> !SYS_CLK)
		else $error("switch while high");
	a_arm_after_timer:
	assert property ($rose(MONITOR_ARMED) |-> OST_EXPIRED)
		else $error("armed early");
	a_sleep_clears:
	assert property (SLEEP_EXEC |-> ##[1:3] !FAIL_SAFE_ACTIVE)
		else $error("sleep kept condition");
	a_no_timer_ec_rc:
	assert property (WAKE_UP && !SLEEP_EXEC && (OSC_MODE == external_clock_mode
		|| OSC_MODE == resistor_capacitor_mode) |-> ##[1:4] OST_EXPIRED)
		else $error("timer not skipped");
	c_fail: cover property ($rose(FAIL_SAFE_ACTIVE));
	c_irq: cover property ($rose(OSC_FAIL_IRQ));
	c_back: cover property ($fell(SYS_CLK_ON_INTERNAL));
endmodule : fsmon_asserts

bind fsmon_top fsmon_asserts u_asserts (.*);

/* File: dv/fail_safe_clock_monitor_tb_top.sv */
// Purpose: Self-checking bench for the fail-safe clock monitor.
// Assumes: Short start-up timer; oscillators made from MCLK.
// Notes:   Every oscillator mode fails once; even modes recover, odd modes are cleared by sleep.
`timescale 1ns/1ps
module fail_safe_clock_monitor_tb_top
	import fsmon_pkg::*;
;
	logic              mclk, rst_b, en, run, slp, wak, irq_en, clr, ext;
	logic [2:0]        div = 3'h0;
	logic [MODE_W-1:0] mode;
	logic [FREQ_W-1:0] fsel, ifreq;
	logic [SCS_W-1:0]  system_clock_select;
	logic [3:0]        half;
	logic              sclk, on_int, flag, irq, act, oscillator_startup_timer, armed;
	int                mismatches = 0;
	int                checks_done = 0;
	int                k;
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) div <= div + 3'h1;
	fsmon_ext_osc u_osc (.clk(mclk), .run(run), .half(half), .osc(ext));
	fsmon_top #(.OST_EDGES(4)) u_dut (.MCLK(mclk), .RST_B(rst_b),
		.EXT_CLK(ext), .LF_OSC_CLK(div[0]), .INT_OSC_CLK(div[2]),
		.FAIL_SAFE_MONITOR_ENABLE(en), .OSC_MODE(mode),
		.INTERNAL_OSC_FREQ_SELECT(fsel), .SYSTEM_CLOCK_SELECT(system_clock_select),
		.SLEEP_EXEC(slp), .WAKE_UP(wak), .OSC_FAIL_IRQ_ENABLE(irq_en),
		.OSC_FAIL_FLAG_CLEAR(clr), .SYS_CLK(sclk), .SYS_CLK_ON_INTERNAL(on_int),
		.INT_OSC_FREQ(ifreq), .OSC_FAIL_FLAG(flag), .OSC_FAIL_IRQ(irq),
		.FAIL_SAFE_ACTIVE(act), .OST_EXPIRED(oscillator_startup_timer), .MONITOR_ARMED(armed));
	function automatic logic no_timer(input logic [MODE_W-1:0] m);
		return m == external_clock_mode || m == resistor_capacitor_mode;
	endfunction : no_timer
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic wait_on(input int s, input int n);
		for (int i = 0; i < n; i++) begin
			cyc(1);
			if ((s == 0 && act === 1'b1) || (s == 1 && oscillator_startup_timer === 1'b1)
				|| (s == 2 && act === 1'b0)) break;
		end
	endtask : wait_on
	task automatic pulse(input int w);
		@(posedge mclk);
		slp <= (w == 0);
		wak <= (w == 1);
		clr <= (w == 2);
		@(posedge mclk);
		{slp, wak, clr} <= 3'h0;
		#1;
	endtask : pulse
	task automatic start(input logic [MODE_W-1:0] m, input logic r);
		@(posedge mclk);
		rst_b <= 1'b0;
		mode <= m;
		run <= r;
		system_clock_select <= 2'h0;
		fsel <= 4'($urandom_range(15));
		irq_en <= 1'($urandom_range(1));
		half <= 4'($urandom_range(4, 1));
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
	endtask : start
	task automatic run_mode(input logic [MODE_W-1:0] m);
		logic nt;
		nt = no_timer(m);
		start(m, !nt);
		wait_on(1, nt ? 6 : 200);
		chk(oscillator_startup_timer, 4'h1);
		chk(ifreq, fsel);
		@(posedge mclk);
		run <= 1'b0;
		wait_on(0, 300);
		chk(act, 4'h1);
		cyc(3);
		chk(flag, 4'h1);
		chk(irq, irq_en);
		cyc(40);
		chk(on_int, 4'h1);
		pulse(2);
		cyc(2);
		chk(flag, 4'h1);
		if (!m[0]) begin
			run <= 1'b1;
			system_clock_select <= 2'h1;
			wait_on(2, 300);
			chk(act, 4'h0);
			cyc(30);
			chk(on_int, 4'h0);
			pulse(2);
			cyc(2);
			chk(flag, 4'h0);
		end else begin
			pulse(0);
			cyc(2);
			chk(act, 4'h0);
			pulse(1);
			cyc(nt ? 4 : 200);
			chk(oscillator_startup_timer, nt);
			if (!nt) chk(act, 4'h0);
		end
	endtask : run_mode
	task automatic conclude();
		if (mismatches == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	initial begin
		{rst_b, run, slp, wak, clr, irq_en} = 6'h0;
		{en, mode, fsel, system_clock_select, half} = {1'b1, 3'h0, 4'h0, 2'h0, 4'h1};
		void'($urandom(75));
		for (k = 0; k < 6; k++) run_mode(3'(k));
		en <= 1'b0;
		start(crystal_mode, 1'b1);
		wait_on(1, 200);
		run <= 1'b0;
		cyc(300);
		chk(act, 4'h0);
		chk(flag, 4'h0);
		conclude();
	end
	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		conclude();
	end
endmodule : fail_safe_clock_monitor_tb_top
